// ---- rtl/ebpc_defines.svh ----
// Offsets, pin positions, reset values and timing counts of the bus pins
`ifndef EBPC_DEFINES_SVH
`define EBPC_DEFINES_SVH

// ****************************************
// Pin positions on the arbitration/select port
// ****************************************
`define EBPC_NUM_CS 5
`define EBPC_HOLD_BIT 5
`define EBPC_GRANT_BIT 6
`define EBPC_CLAIM_BIT 7

// ****************************************
// Bus mode and strobe mode fields
// ****************************************
`define EBPC_MODE_MUX_BIT 0
`define EBPC_MODE_BYTE_BIT 1
`define EBPC_STORE_STROBE_MODE_BIT_LOWBYTE 1'b1

// ****************************************
// Segment lines per address space
// ****************************************
`define EBPC_SEG_LINES_64K 4'h0
`define EBPC_SEG_LINES_256K 4'h2
`define EBPC_SEG_LINES_1M 4'h4
`define EBPC_SEG_LINES_16M 4'h8

// ****************************************
// Reset values and timing
// ****************************************
`define EBPC_PIN_RST_OUT 1'b1
`define EBPC_PIN_RST_OE_N 1'b1
`define EBPC_CS_IDLE 5'h1F
`define EBPC_MIN_STROBE_CYC 3

`endif

// ---- rtl/ebpc_pin_cell.sv ----
// One port pin: function or general output, direction and driver type
`timescale 1ns/1ns
`include "ebpc_defines.svh"

module ebpc_pin_cell
(
   input wire logic clk,
   input wire logic reset,
   input wire logic alt_en,
   input wire logic alt_drive,
   input wire logic alt_val,
   input wire logic gpio_val,
   input wire logic dir,
   input wire logic open_drain,
   output logic pin_out,
   output logic pin_oe_n
);

   logic out_ff;
   logic oe_n_ff;
   logic nxt_out;
   logic nxt_oe_n;
   logic drive;

   always_comb
   begin
      drive = alt_en ? alt_drive : dir;
      nxt_out = alt_en ? alt_val : gpio_val;
      // Input pin or open-drain high both float the driver
      nxt_oe_n = !(drive && !(open_drain && nxt_out));
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         out_ff <= `EBPC_PIN_RST_OUT;
         oe_n_ff <= `EBPC_PIN_RST_OE_N;
      end
      else
      begin
         out_ff <= nxt_out;
         oe_n_ff <= nxt_oe_n;
      end
   end

   assign pin_out = out_ff;
   assign pin_oe_n = oe_n_ff;

endmodule : ebpc_pin_cell

// ---- rtl/ebpc_pkg.sv ----
// Types shared by the external bus pin logic
package ebpc_pkg;

   typedef enum logic [1:0] {ACC_IDLE, ACC_ADDR, ACC_STROBE} ebpc_acc_state_t;

   typedef enum logic [1:0]
   {
      ARB_OWN,
      ARB_LENT,
      ARB_SLV_IDLE,
      ARB_SLV_REQ
   } ebpc_arb_state_t;

   typedef enum logic [1:0]
   {
      SPACE_64K,
      SPACE_256K,
      SPACE_1M,
      SPACE_16M
   } ebpc_space_t;

endpackage : ebpc_pkg

// ---- rtl/ebpc_sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns

module ebpc_sync2
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   // No reset: the strap must pass even while reset is held
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clk)
   begin
      meta_ff <= d;
      q_ff <= meta_ff;
   end

   assign q = q_ff;

endmodule : ebpc_sync2

// ---- rtl/ebpc_top.sv ----
// External bus pin control: strobes, selects, arbitration and ports
`timescale 1ns/1ns
`include "ebpc_defines.svh"

// Overview of operation
// - Five active-low chip selects sit on arbitration port bits zero to four.
// - Grant pin is an output as master and an input as slave.
// - Device drives a bus claim request to get the bus back or borrow it.
// - Every port bit has its own direction control.
// - A general-purpose port bit set as input has its driver floated.
// - Each arbitration port driver is push-pull or open-drain per pin.
// - Single-strobe mode pulses the write strobe on every external write.
// - Low-byte mode strobes low-byte writes on 16-bit, all on 8-bit bus.
// - A configuration bit chooses between the two write strobe modes.
// - Ready enabled and ready high stretch the access with wait states.
// - Multiplexed modes give an address latch pulse before the strobe.
// - Fetch strap low means external fetch, sampled during and after reset.
// - Segment port carries address 16 at bit zero up to 23 at bit seven.
// - Arbitration runs only once the arbitration enable bit is set.
// - Master role after reset; claim pin direction bit set selects slave.
// - Address space 1M, 256K, 64K gives four, two, no segment lines.
// - Demultiplexed: address on second port; multiplexed: all on first.
module ebpc_top
#(
   parameter logic [31:0] WIN_BASE = 32'h04030201,
   parameter logic [31:0] WIN_MASK = 32'hFFFFFFFF,
   parameter int MIN_STROBE = `EBPC_MIN_STROBE_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [1:0] acc_byte_en,
   input wire logic [23:0] acc_addr,
   input wire logic [15:0] acc_wdata,
   output logic acc_done,
   output logic [15:0] acc_rdata,
   output logic acc_busy,
   input wire logic bus_enable,
   input wire logic [1:0] bus_mode,
   input wire ebpc_pkg::ebpc_space_t addr_space,
   input wire logic store_strobe_mode_bit,
   input wire logic ready_enable,
   input wire logic arbitration_enable_bit,
   input wire logic [7:0] arb_port_dir,
   input wire logic [7:0] arb_port_od,
   input wire logic [7:0] arb_port_gpio,
   input wire logic [7:0] seg_port_dir,
   input wire logic [7:0] seg_port_gpio,
   input wire logic [7:0] arb_port_in,
   output logic [7:0] arb_port_out,
   output logic [7:0] arb_port_oe_n,
   output logic [7:0] seg_port_out,
   output logic [7:0] seg_port_oe_n,
   input wire logic [15:0] first_bus_port_in,
   output logic [15:0] first_bus_port_out,
   output logic [15:0] first_bus_port_oe_n,
   output logic [15:0] second_bus_port_out,
   output logic [15:0] second_bus_port_oe_n,
   output logic ale_out,
   output logic rd_n_out,
   output logic low_byte_store_strobe_n,
   output logic ctl_oe_n,
   input wire logic ready_pin,
   input wire logic fetch_source_strap,
   output logic fetch_from_external
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] ctl_sync;
   logic [15:0] data_sync;
   logic hold_sync_n;
   logic grant_in_sync_n;
   logic ready_sync;
   logic strap_sync;

   ebpc_sync2 #(.WIDTH(4)) u_ctl_sync
   (
      .clk(clk),
      .d({ready_pin, fetch_source_strap, arb_port_in[`EBPC_GRANT_BIT],
          arb_port_in[`EBPC_HOLD_BIT]}),
      .q(ctl_sync)
   );

   ebpc_sync2 #(.WIDTH(16)) u_data_sync
   (
      .clk(clk),
      .d(first_bus_port_in),
      .q(data_sync)
   );

   assign hold_sync_n = ctl_sync[0];
   assign grant_in_sync_n = ctl_sync[1];
   assign strap_sync = ctl_sync[2];
   assign ready_sync = ctl_sync[3];

   // ****************************************
   // Address window decode
   // ****************************************
   function automatic logic [4:0] cs_decode(input logic [23:0] a);
      logic [4:0] sel;
      logic hit;
      sel = `EBPC_CS_IDLE;
      hit = 1'b0;
      // Highest window wins, select zero covers the rest
      for (int i = 4; i >= 1; i--)
      begin
         if (!hit && ((a[23:16] & WIN_MASK[(i-1)*8 +: 8]) ==
                      (WIN_BASE[(i-1)*8 +: 8] & WIN_MASK[(i-1)*8 +: 8])))
         begin
            sel[i] = 1'b0;
            hit = 1'b1;
         end
      end
      if (!hit)
      begin
         sel[0] = 1'b0;
      end
      return sel;
   endfunction : cs_decode

   // ****************************************
   // Arbitration
   // ****************************************
   ebpc_pkg::ebpc_arb_state_t arb_state_ff;
   ebpc_pkg::ebpc_arb_state_t nxt_arb_state;
   ebpc_pkg::ebpc_acc_state_t acc_state_ff;
   ebpc_pkg::ebpc_acc_state_t nxt_acc_state;
   logic slave_role;
   logic hold_pending;
   logic acc_idle;
   logic acc_start;
   logic nxt_owned;
   logic nxt_grant_n;
   logic nxt_claim_n;
   logic grant_n_ff;

   assign slave_role = arb_port_dir[`EBPC_CLAIM_BIT];
   assign hold_pending = arbitration_enable_bit && !slave_role && !hold_sync_n;
   assign acc_idle = (acc_state_ff == ebpc_pkg::ACC_IDLE);
   assign acc_start = acc_idle && acc_req && !hold_pending &&
                      (arb_state_ff == ebpc_pkg::ARB_OWN);

   always_comb
   begin
      nxt_arb_state = arb_state_ff;
      if (!arbitration_enable_bit)
      begin
         nxt_arb_state = ebpc_pkg::ARB_OWN;
      end
      else
      begin
         unique case (arb_state_ff)
            ebpc_pkg::ARB_OWN:
            begin
               // Never lend mid-access: a stranded strobe corrupts memory
               if (!slave_role && hold_pending && acc_idle)
                  nxt_arb_state = ebpc_pkg::ARB_LENT;
               else if (slave_role && acc_idle && !acc_req)
                  nxt_arb_state = ebpc_pkg::ARB_SLV_IDLE;
            end
            ebpc_pkg::ARB_LENT:
            begin
               if (!hold_pending)
                  nxt_arb_state = ebpc_pkg::ARB_OWN;
            end
            ebpc_pkg::ARB_SLV_IDLE:
            begin
               if (!slave_role)
                  nxt_arb_state = ebpc_pkg::ARB_OWN;
               else if (acc_req)
                  nxt_arb_state = ebpc_pkg::ARB_SLV_REQ;
            end
            ebpc_pkg::ARB_SLV_REQ:
            begin
               if (!slave_role || !grant_in_sync_n)
                  nxt_arb_state = ebpc_pkg::ARB_OWN;
            end
         endcase
      end
      nxt_owned = (nxt_arb_state == ebpc_pkg::ARB_OWN);
      nxt_grant_n = (nxt_arb_state != ebpc_pkg::ARB_LENT);
      nxt_claim_n = !((nxt_arb_state == ebpc_pkg::ARB_LENT && acc_req) ||
                      (slave_role && arbitration_enable_bit &&
                       nxt_arb_state != ebpc_pkg::ARB_SLV_IDLE));
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         arb_state_ff <= ebpc_pkg::ARB_OWN;
         grant_n_ff <= 1'b1;
      end
      else
      begin
         arb_state_ff <= nxt_arb_state;
         grant_n_ff <= nxt_grant_n;
      end
   end

   // ****************************************
   // Access sequencer
   // ****************************************
   logic [23:0] addr_ff;
   logic [23:0] nxt_addr;
   logic [15:0] wdata_ff;
   logic [15:0] nxt_wdata;
   logic write_ff;
   logic nxt_write;
   logic [1:0] be_ff;
   logic [1:0] nxt_be;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [4:0] sel_ff;
   logic [4:0] nxt_sel;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic done_ff;
   logic nxt_done;
   logic wait_req;

   assign wait_req = ready_enable && ready_sync;

   always_comb
   begin
      nxt_acc_state = acc_state_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_write = write_ff;
      nxt_be = be_ff;
      nxt_cnt = cnt_ff;
      nxt_sel = sel_ff;
      nxt_rdata = rdata_ff;
      nxt_done = 1'b0;
      unique case (acc_state_ff)
         ebpc_pkg::ACC_IDLE:
         begin
            if (acc_start)
            begin
               nxt_acc_state = ebpc_pkg::ACC_ADDR;
               nxt_addr = acc_addr;
               nxt_wdata = acc_wdata;
               nxt_write = acc_write;
               nxt_be = acc_byte_en;
               nxt_sel = cs_decode(acc_addr);
            end
         end
         ebpc_pkg::ACC_ADDR:
         begin
            nxt_acc_state = ebpc_pkg::ACC_STROBE;
            nxt_cnt = 4'h0;
         end
         ebpc_pkg::ACC_STROBE:
         begin
            if (cnt_ff != 4'hF)
               nxt_cnt = cnt_ff + 4'h1;
            // Least strobe covers the data synchroniser delay
            if (cnt_ff >= 4'(MIN_STROBE - 1) && !wait_req)
            begin
               nxt_acc_state = ebpc_pkg::ACC_IDLE;
               nxt_done = 1'b1;
               nxt_sel = `EBPC_CS_IDLE;
               if (!write_ff)
                  nxt_rdata = data_sync;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         acc_state_ff <= ebpc_pkg::ACC_IDLE;
         addr_ff <= 24'h000000;
         wdata_ff <= 16'h0000;
         write_ff <= 1'b0;
         be_ff <= 2'h0;
         cnt_ff <= 4'h0;
         sel_ff <= `EBPC_CS_IDLE;
         rdata_ff <= 16'h0000;
         done_ff <= 1'b0;
      end
      else
      begin
         acc_state_ff <= nxt_acc_state;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         write_ff <= nxt_write;
         be_ff <= nxt_be;
         cnt_ff <= nxt_cnt;
         sel_ff <= nxt_sel;
         rdata_ff <= nxt_rdata;
         done_ff <= nxt_done;
      end
   end

   // ****************************************
   // Bus pins, registered from next state
   // ****************************************
   logic mux_mode;
   logic byte_bus;
   logic strobe_ph;
   logic addr_ph;
   logic wr_sel;
   logic nxt_ale;
   logic nxt_rd_n;
   logic nxt_wr_n;
   logic [15:0] nxt_b0_out;
   logic [15:0] nxt_b0_oe_n;
   logic [15:0] nxt_b1_oe_n;
   logic ale_ff;
   logic rd_n_ff;
   logic wr_n_ff;
   logic ctl_oe_n_ff;
   logic busy_ff;
   logic [15:0] b0_out_ff;
   logic [15:0] b0_oe_n_ff;
   logic [15:0] b1_out_ff;
   logic [15:0] b1_oe_n_ff;

   assign mux_mode = bus_mode[`EBPC_MODE_MUX_BIT];
   assign byte_bus = bus_mode[`EBPC_MODE_BYTE_BIT];

   always_comb
   begin
      addr_ph = (nxt_acc_state == ebpc_pkg::ACC_ADDR);
      strobe_ph = (nxt_acc_state == ebpc_pkg::ACC_STROBE);
      wr_sel = (store_strobe_mode_bit != `EBPC_STORE_STROBE_MODE_BIT_LOWBYTE) ||
               byte_bus || nxt_be[0];
      nxt_ale = addr_ph && mux_mode;
      nxt_rd_n = !(strobe_ph && !nxt_write);
      nxt_wr_n = !(strobe_ph && nxt_write && wr_sel);
      nxt_b0_out = (addr_ph && mux_mode) ? nxt_addr[15:0] : nxt_wdata;
      nxt_b0_oe_n = 16'hFFFF;
      nxt_b1_oe_n = 16'hFFFF;
      if (nxt_owned)
      begin
         if (addr_ph && mux_mode)
            nxt_b0_oe_n = 16'h0000;
         else if (strobe_ph && nxt_write)
            nxt_b0_oe_n = byte_bus ? 16'hFF00 : 16'h0000;
         if (!mux_mode && nxt_acc_state != ebpc_pkg::ACC_IDLE)
            nxt_b1_oe_n = 16'h0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ale_ff <= 1'b0;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         ctl_oe_n_ff <= 1'b1;
         busy_ff <= 1'b0;
         b0_out_ff <= 16'h0000;
         b0_oe_n_ff <= 16'hFFFF;
         b1_out_ff <= 16'h0000;
         b1_oe_n_ff <= 16'hFFFF;
      end
      else
      begin
         ale_ff <= nxt_ale;
         rd_n_ff <= nxt_rd_n;
         wr_n_ff <= nxt_wr_n;
         ctl_oe_n_ff <= !nxt_owned;
         busy_ff <= (nxt_acc_state != ebpc_pkg::ACC_IDLE);
         b0_out_ff <= nxt_b0_out;
         b0_oe_n_ff <= nxt_b0_oe_n;
         b1_out_ff <= nxt_addr[15:0];
         b1_oe_n_ff <= nxt_b1_oe_n;
      end
   end

   // ****************************************
   // Port pin cells
   // ****************************************
   logic [3:0] seg_lines;
   logic [7:0] arb_alt_en;
   logic [7:0] arb_alt_drive;
   logic [7:0] arb_alt_val;
   logic [7:0] seg_alt_en;

   always_comb
   begin
      unique case (addr_space)
         ebpc_pkg::SPACE_64K: seg_lines = `EBPC_SEG_LINES_64K;
         ebpc_pkg::SPACE_256K: seg_lines = `EBPC_SEG_LINES_256K;
         ebpc_pkg::SPACE_1M: seg_lines = `EBPC_SEG_LINES_1M;
         ebpc_pkg::SPACE_16M: seg_lines = `EBPC_SEG_LINES_16M;
      endcase
      for (int i = 0; i < 8; i++)
         seg_alt_en[i] = bus_enable && (4'(i) < seg_lines);
      arb_alt_en = {{3{arbitration_enable_bit}}, {5{bus_enable}}};
      arb_alt_drive = {1'b1, !slave_role, 1'b0, {5{nxt_owned}}};
      arb_alt_val = {nxt_claim_n, nxt_grant_n, 1'b1, nxt_sel};
   end

   for (genvar g = 0; g < 8; g++)
   begin : g_pins
      ebpc_pin_cell u_arb_cell
      (
         .clk(clk),
         .reset(reset),
         .alt_en(arb_alt_en[g]),
         .alt_drive(arb_alt_drive[g]),
         .alt_val(arb_alt_val[g]),
         .gpio_val(arb_port_gpio[g]),
         .dir(arb_port_dir[g]),
         .open_drain(arb_port_od[g]),
         .pin_out(arb_port_out[g]),
         .pin_oe_n(arb_port_oe_n[g])
      );
      ebpc_pin_cell u_seg_cell
      (
         .clk(clk),
         .reset(reset),
         .alt_en(seg_alt_en[g]),
         .alt_drive(nxt_owned),
         .alt_val(nxt_addr[16+g]),
         .gpio_val(seg_port_gpio[g]),
         .dir(seg_port_dir[g]),
         .open_drain(1'b0),
         .pin_out(seg_port_out[g]),
         .pin_oe_n(seg_port_oe_n[g])
      );
   end

   // ****************************************
   // Fetch source strap
   // ****************************************
   logic post_rst_ff;
   logic fetch_ext_ff;
   logic nxt_fetch_ext;

   // Keeps following the strap through reset and one cycle after
   assign nxt_fetch_ext = (reset || post_rst_ff) ? !strap_sync
                                                 : fetch_ext_ff;

   always_ff @(posedge clk)
   begin
      post_rst_ff <= reset;
      fetch_ext_ff <= nxt_fetch_ext;
   end

   assign acc_done = done_ff;
   assign acc_rdata = rdata_ff;
   assign acc_busy = busy_ff;
   assign first_bus_port_out = b0_out_ff;
   assign first_bus_port_oe_n = b0_oe_n_ff;
   assign second_bus_port_out = b1_out_ff;
   assign second_bus_port_oe_n = b1_oe_n_ff;
   assign ale_out = ale_ff;
   assign rd_n_out = rd_n_ff;
   assign low_byte_store_strobe_n = wr_n_ff;
   assign ctl_oe_n = ctl_oe_n_ff;
   assign fetch_from_external = fetch_ext_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_single_strobe;
      acc_state_ff == ebpc_pkg::ACC_STROBE && write_ff &&
      $past(store_strobe_mode_bit) != `EBPC_STORE_STROBE_MODE_BIT_LOWBYTE |-> !wr_n_ff;
   endproperty
   a_single_strobe: assert property (p_single_strobe)
      else $error("write strobe missing in single-strobe mode");

   property p_low_byte_skip;
      acc_state_ff == ebpc_pkg::ACC_STROBE && !be_ff[0] &&
      $past(store_strobe_mode_bit) == `EBPC_STORE_STROBE_MODE_BIT_LOWBYTE &&
      !$past(byte_bus) |-> wr_n_ff;
   endproperty
   a_low_byte_skip: assert property (p_low_byte_skip)
      else $error("write strobe on high-byte write in low-byte mode");

   property p_wait_state;
      acc_state_ff == ebpc_pkg::ACC_STROBE && wait_req
      |=> acc_state_ff == ebpc_pkg::ACC_STROBE;
   endproperty
   a_wait_state: assert property (p_wait_state)
      else $error("access ended while ready requested wait");

   property p_ale_then_strobe;
      ale_ff |=> acc_state_ff == ebpc_pkg::ACC_STROBE && ale_ff == 1'b0;
   endproperty
   a_ale_then_strobe: assert property (p_ale_then_strobe)
      else $error("latch pulse not followed by strobe phase");

   property p_cs_idle;
      acc_idle |-> sel_ff == `EBPC_CS_IDLE;
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("select active outside an access");

   property p_cs_onehot;
      !acc_idle |-> $countones(~sel_ff) == 1;
   endproperty
   a_cs_onehot: assert property (p_cs_onehot)
      else $error("not exactly one select during access");

   property p_release;
      arb_state_ff != ebpc_pkg::ARB_OWN
      |-> ctl_oe_n_ff && (&b0_oe_n_ff) && (&b1_oe_n_ff) && acc_idle;
   endproperty
   a_release: assert property (p_release)
      else $error("bus driven while not owned");

   property p_arb_off;
      !arbitration_enable_bit |=> arb_state_ff == ebpc_pkg::ARB_OWN;
   endproperty
   a_arb_off: assert property (p_arb_off)
      else $error("arbitration active while disabled");

   property p_grant;
      arb_state_ff == ebpc_pkg::ARB_LENT |-> !grant_n_ff;
   endproperty
   a_grant: assert property (p_grant)
      else $error("grant not given while bus lent");

   property p_strap_hold;
      !post_rst_ff |=> $stable(fetch_ext_ff);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("fetch source changed after reset window");

   c_write: cover property (acc_state_ff == ebpc_pkg::ACC_STROBE && !wr_n_ff);
   c_wait: cover property (acc_state_ff == ebpc_pkg::ACC_STROBE && wait_req);
   c_lent: cover property (arb_state_ff == ebpc_pkg::ARB_LENT);
   c_slave: cover property (arb_state_ff == ebpc_pkg::ARB_SLV_REQ
                            ##1 arb_state_ff == ebpc_pkg::ARB_OWN);

endmodule : ebpc_top

// ---- testbench/ebpc_ext_mem.sv ----
// Model of external memory and of a second bus master at the pins
`timescale 1ns/1ns

module ebpc_ext_mem
(
   input wire logic clk,
   input wire logic rd_n_out,
   input wire logic ale_out,
   input wire logic [15:0] first_bus_port_out,
   input wire logic [15:0] second_bus_port_out,
   input wire logic [15:0] second_bus_port_oe_n,
   input wire logic [3:0] wait_cyc,
   input wire logic want_bus,
   output logic [15:0] first_bus_port_in,
   output logic ready_pin,
   output logic [7:0] arb_port_in
);
   logic [15:0] addr_ff = 16'h0000;
   logic [15:0] last_ff = 16'h0000;
   logic [3:0] wait_ff = 4'h0;
   logic rd_d_ff = 1'b1;

   // Released data bus toggles so stale data never matches
   assign first_bus_port_in = (rd_n_out === 1'b0) ?
      addr_ff ^ 16'h5A5A : ~last_ff;
   // Ready rises with the read strobe so the device sees it in time
   assign ready_pin = (wait_ff != 4'h0) ||
      (rd_d_ff && rd_n_out === 1'b0);
   assign arb_port_in = {2'h3, ~want_bus, 5'h1F};

   always @(posedge clk)
   begin
      rd_d_ff <= rd_n_out;
      last_ff <= first_bus_port_in;
      if (ale_out === 1'b1)
         addr_ff <= first_bus_port_out;
      else if (second_bus_port_oe_n[0] === 1'b0)
         addr_ff <= second_bus_port_out;
      if (rd_d_ff && rd_n_out === 1'b0)
         wait_ff <= wait_cyc;
      else if (wait_ff != 4'h0)
         wait_ff <= wait_ff - 4'h1;
   end
endmodule : ebpc_ext_mem

// ---- testbench/tb_ebpc_top.sv ----
// Self-checking bench for the external bus pin control block
`timescale 1ns/1ns

module tb_ebpc_top;
   logic clk, reset, acc_req, acc_write, acc_done, acc_busy, bus_enable;
   logic store_strobe_mode_bit, ready_enable, arbitration_enable_bit;
   logic ale_out, rd_n_out, low_byte_store_strobe_n, ctl_oe_n, ready_pin;
   logic fetch_source_strap, fetch_from_external, want_bus, saw_wr, saw_ale;
   logic [1:0] acc_byte_en, bus_mode;
   logic [3:0] wait_cyc;
   logic [4:0] cs;
   logic [23:0] acc_addr;
   logic [7:0] arb_port_dir, arb_port_od, arb_port_gpio, seg_port_dir;
   logic [7:0] seg_port_gpio, arb_port_in, arb_port_out, arb_port_oe_n;
   logic [7:0] seg_port_out, seg_port_oe_n, seg, so;
   logic [15:0] acc_wdata, acc_rdata, first_bus_port_in, a2;
   logic [15:0] first_bus_port_out, first_bus_port_oe_n;
   logic [15:0] second_bus_port_out, second_bus_port_oe_n;
   ebpc_pkg::ebpc_space_t addr_space;
   int n_mismatch, num_checks, n;

   ebpc_top dut (.*);
   ebpc_ext_mem mem (.*);

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic tk;
      @(posedge clk);
      #1;
   endtask : tk

   task automatic go(input logic w, input logic [1:0] be,
      input logic [23:0] a);
      tk();
      {acc_req, acc_write, acc_byte_en, acc_addr} = {1'b1, w, be, a};
   endtask : go

   // Samples pins each cycle until done; bounded so a hang shows up
   task automatic fin;
      n = 0;
      {saw_wr, saw_ale} = 2'h0;
      while (acc_done !== 1'b1 && n < 40)
      begin
         tk();
         n++;
         saw_ale |= (ale_out === 1'b1);
         if (low_byte_store_strobe_n === 1'b0 || rd_n_out === 1'b0)
         begin
            saw_wr |= (low_byte_store_strobe_n === 1'b0);
            {cs, seg, so} = {arb_port_out[4:0], seg_port_out, seg_port_oe_n};
            a2 = second_bus_port_out;
         end
      end
      acc_req = 1'b0;
   endtask : fin

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      summarize();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      reset = 1'b1;
      {acc_req, acc_write, bus_enable, store_strobe_mode_bit} = 4'h2;
      {ready_enable, arbitration_enable_bit, want_bus} = 3'h0;
      fetch_source_strap = 1'b0;
      {acc_byte_en, bus_mode, wait_cyc, acc_addr} = 32'h0;
      {arb_port_dir, arb_port_od, arb_port_gpio} = 24'h7F00FF;
      {seg_port_dir, seg_port_gpio, acc_wdata} = 32'hFF00BEEF;
      addr_space = ebpc_pkg::SPACE_16M;
      repeat (10) tk();
      chk("oe", 32'h1FFFF, {ctl_oe_n, arb_port_oe_n, seg_port_oe_n});
      reset = 1'b0;
      tk();
      chk("fetch", 32'h1, fetch_from_external);
      $display("test 1 done");
      go(1'b1, 2'h3, 24'h021234);
      fin();
      chk("lat", 32'h5, n);
      chk("wr", 32'h1, saw_wr);
      chk("cs", 32'h1B, cs);
      chk("seg", 32'h02, seg);
      chk("addr", 32'h1234, a2);
      chk("ale", 32'h0, saw_ale);
      $display("test 2 done");
      store_strobe_mode_bit = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         bus_mode = (i == 2) ? 2'h2 : 2'h0;
         go(1'b1, (i == 1) ? 2'h1 : 2'h2, 24'h030010);
         fin();
         chk("wrl", i != 0, saw_wr);
      end
      $display("test 3 done");
      {store_strobe_mode_bit, bus_mode, seg_port_dir} = 11'h100;
      addr_space = ebpc_pkg::SPACE_1M;
      go(1'b0, 2'h3, 24'h1500F0);
      fin();
      chk("ale", 32'h1, saw_ale);
      chk("rdat", 32'h5AAA, acc_rdata);
      chk("cs0", 32'h1E, cs);
      chk("segoe", 32'hF0, so);
      chk("seg", 32'h05, seg);
      $display("test 4 done");
      wait_cyc = 4'h4;
      for (int i = 0; i < 2; i++)
      begin
         ready_enable = i[0];
         go(1'b0, 2'h3, 24'h150100);
         fin();
         chk("wait", i, n > 6);
         chk("rdat", 32'h5B5A, acc_rdata);
      end
      $display("test 5 done");
      want_bus = 1'b1;
      repeat (6) tk();
      chk("grant", 32'h1, arb_port_out[6]);
      arbitration_enable_bit = 1'b1;
      repeat (6) tk();
      chk("grant", 32'h0, arb_port_out[6]);
      chk("float", 32'h3FFFF, {ctl_oe_n, arb_port_oe_n[0],
         first_bus_port_oe_n});
      go(1'b1, 2'h3, 24'h040002);
      repeat (4) tk();
      chk("claim", 32'h0, arb_port_out[7]);
      chk("busy", 32'h0, acc_busy);
      want_bus = 1'b0;
      fin();
      chk("cs4", 32'h0F, cs);
      arb_port_dir = 8'hFF;
      go(1'b0, 2'h3, 24'h000000);
      repeat (4) tk();
      chk("slave", 32'h3, {arb_port_out[7], arb_port_oe_n[6],
         ctl_oe_n});
      arb_port_dir = 8'h7F;
      fin();
      chk("own", 32'h1E, cs);
      $display("test 6 done");
      {bus_enable, seg_port_dir, seg_port_gpio} = 17'h00FA5;
      {arb_port_od, arb_port_gpio} = 16'h01FE;
      repeat (3) tk();
      chk("segoe", 32'hF0, seg_port_oe_n);
      chk("segv", 32'h5, seg_port_out[3:0]);
      chk("od0", 32'h0, arb_port_oe_n[0]);
      arb_port_gpio = 8'hFF;
      repeat (3) tk();
      chk("od1", 32'h1, arb_port_oe_n[0]);
      $display("test 7 done");
      summarize();
   end
endmodule : tb_ebpc_top
